// *** common/monitor_panel_pkg.sv ***
// Constants and carrier types of the monitor front-panel logic
// Notes on behaviour
// - Each start/stop press toggles monitoring between idle and running.
// - Start/stop button lamp is lit exactly while monitoring runs.
// - Each condition has a present indicator and a latched indicator.
// - Flag quality and clean-voltage errors when measures fall below limits.
// - Flag edge errors when edge duration exceeds its configured limit.
// - Starting monitoring clears all present and latched indicators.
// - Present indicator lit only while condition holds and monitoring runs.
// - Latched indicator sets on first occurrence, holds until next start.
// - Each latched indicator can be routed by configuration to the isolated output.
// - Bus-activity indicator shows current traffic on the bus.
// - Holding rear button for full interval restores defaults, then restart.
// - While monitoring, every threshold deviation is recorded as an event.
`default_nettype none
package monitor_panel_pkg;

  localparam int unsigned NUM_COND = 8;
  localparam int unsigned MEAS_W = 8;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned HOLD_SECONDS = 10;
  localparam int unsigned HOLD_CYCLES = HOLD_SECONDS * CLK_HZ;
  localparam int unsigned HOLD_W = 32;
  localparam int unsigned DEBOUNCE_CYCLES = 400_000;

  // Bit positions of the conditions
  localparam int unsigned IDX_ACTIVE_ERR = 0;
  localparam int unsigned IDX_PASSIVE_ERR = 1;
  localparam int unsigned IDX_OVERLOAD = 2;
  localparam int unsigned IDX_ACK_ERR = 3;
  localparam int unsigned IDX_QUALITY = 4;
  localparam int unsigned IDX_VOLTAGE = 5;
  localparam int unsigned IDX_RISING = 6;
  localparam int unsigned IDX_FALLING = 7;

  typedef struct packed {
    logic active_error_frame_seen;
    logic passive_error_frame_seen;
    logic overload_frame_seen;
    logic ack_error_seen;
  } logical_events_t;

  typedef struct packed {
    logic [MEAS_W-1:0] quality;
    logic [MEAS_W-1:0] clean_voltage;
    logic [MEAS_W-1:0] rise_time;
    logic [MEAS_W-1:0] fall_time;
  } measures_t;

  typedef struct packed {
    logic [MEAS_W-1:0] quality_min;
    logic [MEAS_W-1:0] voltage_min;
    logic [MEAS_W-1:0] rise_max;
    logic [MEAS_W-1:0] fall_max;
  } limits_t;

  typedef enum logic [1:0] {
    MON_IDLE = 2'h1,
    MON_RUN = 2'h2
  } mon_state_t;

  localparam logic [NUM_COND-1:0] COND_NONE = 8'h00;

endpackage : monitor_panel_pkg
`default_nettype wire

// *** hdl/hold_detector.sv ***
// Long-press detector for the rear restore button, count restarts on any release
`default_nettype none
module hold_detector #(
  parameter int unsigned HOLD_CYCLES = monitor_panel_pkg::HOLD_CYCLES,
  parameter int unsigned CNT_W = monitor_panel_pkg::HOLD_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pressed,
  output logic fired
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic done;
    logic fired;
  } hold_state_t;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HOLD_CYCLES - 1);

  hold_state_t st;
  hold_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.fired = 1'b0;
    if (!pressed) begin
      next_st.count = '0;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      if (st.count == LAST) begin
        next_st.fired = 1'b1;
        next_st.done = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fired = st.fired;

endmodule // hold_detector
`default_nettype wire

// *** hdl/monitor_panel.sv ***
// Front-panel control and error indication of the bus monitor
`default_nettype none
module monitor_panel #(
  parameter int unsigned HOLD_CYCLES = monitor_panel_pkg::HOLD_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = monitor_panel_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start_stop_button,
  input wire logic restore_button,
  input wire logic bus_traffic,
  input wire monitor_panel_pkg::logical_events_t logical_events,
  input wire monitor_panel_pkg::measures_t measures,
  input wire logic measures_valid,
  input wire monitor_panel_pkg::limits_t limits,
  input wire logic [monitor_panel_pkg::NUM_COND-1:0] output_assign,
  output logic start_stop_lamp,
  output logic bus_activity_led,
  output logic [monitor_panel_pkg::NUM_COND-1:0] present_led,
  output logic [monitor_panel_pkg::NUM_COND-1:0] latched_led,
  output logic isolated_error_out,
  output logic deviation_event,
  output logic [monitor_panel_pkg::NUM_COND-1:0] deviation_code,
  output logic restore_defaults,
  output logic restart_request
);

  localparam int unsigned N = monitor_panel_pkg::NUM_COND;
  localparam int unsigned W = monitor_panel_pkg::MEAS_W;
  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] ss_sync;
    logic [1:0] rst_sync;
    logic [1:0] bus_sync;
    monitor_panel_pkg::logical_events_t ev_sync0;
    monitor_panel_pkg::logical_events_t ev_sync1;
    logic ss_stable;
    logic [DB_W-1:0] db_count;
    monitor_panel_pkg::mon_state_t mode;
    logic [N-1:0] cond;
    logic [N-1:0] prev_cond;
    logic lamp;
    logic bus_led;
    logic [N-1:0] present;
    logic [N-1:0] latched;
    logic iso_out;
    logic dev_event;
    logic [N-1:0] dev_code;
    logic restore;
    logic restart;
  } panel_state_t;

  panel_state_t st;
  panel_state_t next_st;
  logic hold_fired;

  // Unsigned threshold comparison shared by the physical checks
  function automatic logic exceeds(input logic [W-1:0] value,
                                   input logic [W-1:0] limit);
    exceeds = value > limit;
  endfunction

  // ----------------------------------------------------------------
  // Rear button long press
  // ----------------------------------------------------------------
  hold_detector #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .CNT_W(monitor_panel_pkg::HOLD_W)
  ) u_hold (
    .clk(clk),
    .rst_n(rst_n),
    .pressed(st.rst_sync[1]),
    .fired(hold_fired)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [N-1:0] c;
    logic press;
    logic starting;
    logic running;
    c = '0;
    press = 1'b0;
    starting = 1'b0;
    running = 1'b0;
    next_st = st;

    // ------------------------------------------------------------
    // Two-stage synchronisers on the pin inputs
    // ------------------------------------------------------------
    next_st.ss_sync = {st.ss_sync[0], start_stop_button};
    next_st.rst_sync = {st.rst_sync[0], restore_button};
    next_st.bus_sync = {st.bus_sync[0], bus_traffic};
    next_st.ev_sync0 = logical_events;
    next_st.ev_sync1 = st.ev_sync0;

    // ------------------------------------------------------------
    // Start/stop debounce
    // ------------------------------------------------------------
    // Level must differ for the whole window before it is accepted
    if (st.ss_sync[1] == st.ss_stable) begin
      next_st.db_count = '0;
    end else if (st.db_count == DB_LAST) begin
      next_st.db_count = '0;
      next_st.ss_stable = st.ss_sync[1];
      press = st.ss_sync[1];
    end else begin
      next_st.db_count = st.db_count + 1'b1;
    end

    // ------------------------------------------------------------
    // Monitoring mode
    // ------------------------------------------------------------
    // Accepted press of the button toggles the mode
    case (st.mode)
      monitor_panel_pkg::MON_IDLE: begin
        if (press) begin
          next_st.mode = monitor_panel_pkg::MON_RUN;
          starting = 1'b1;
        end
      end
      monitor_panel_pkg::MON_RUN: begin
        if (press) begin
          next_st.mode = monitor_panel_pkg::MON_IDLE;
        end
      end
      default: begin
        next_st.mode = monitor_panel_pkg::MON_IDLE;
      end
    endcase
    // Next mode, so lamp and indicators switch on the same edge
    running = (next_st.mode == monitor_panel_pkg::MON_RUN);
    next_st.lamp = running;

    // ------------------------------------------------------------
    // Condition vector, one bit per monitored condition
    // ------------------------------------------------------------
    // Logical events by field, not by bit order of the carrier
    c[monitor_panel_pkg::IDX_ACTIVE_ERR] =
      st.ev_sync1.active_error_frame_seen;
    c[monitor_panel_pkg::IDX_PASSIVE_ERR] =
      st.ev_sync1.passive_error_frame_seen;
    c[monitor_panel_pkg::IDX_OVERLOAD] =
      st.ev_sync1.overload_frame_seen;
    c[monitor_panel_pkg::IDX_ACK_ERR] =
      st.ev_sync1.ack_error_seen;
    // Physical conditions keep their value between measurements
    c[monitor_panel_pkg::IDX_QUALITY] = st.cond[monitor_panel_pkg::IDX_QUALITY];
    c[monitor_panel_pkg::IDX_VOLTAGE] = st.cond[monitor_panel_pkg::IDX_VOLTAGE];
    c[monitor_panel_pkg::IDX_RISING] = st.cond[monitor_panel_pkg::IDX_RISING];
    c[monitor_panel_pkg::IDX_FALLING] = st.cond[monitor_panel_pkg::IDX_FALLING];
    if (measures_valid) begin
      c[monitor_panel_pkg::IDX_QUALITY] =
        exceeds(limits.quality_min, measures.quality);
      c[monitor_panel_pkg::IDX_VOLTAGE] =
        exceeds(limits.voltage_min, measures.clean_voltage);
      c[monitor_panel_pkg::IDX_RISING] =
        exceeds(measures.rise_time, limits.rise_max);
      c[monitor_panel_pkg::IDX_FALLING] =
        exceeds(measures.fall_time, limits.fall_max);
    end
    next_st.cond = c;
    next_st.prev_cond = running ? c : monitor_panel_pkg::COND_NONE;

    // ------------------------------------------------------------
    // Indicator pair per condition
    // ------------------------------------------------------------
    next_st.present = running ? c : monitor_panel_pkg::COND_NONE;
    // Clear wins at start; a lasting condition sets again next edge
    if (starting) begin
      next_st.latched = monitor_panel_pkg::COND_NONE;
      next_st.present = monitor_panel_pkg::COND_NONE;
      next_st.prev_cond = monitor_panel_pkg::COND_NONE;
    end else if (running) begin
      next_st.latched = st.latched | c;
    end

    next_st.iso_out = |(next_st.latched & output_assign);
    next_st.bus_led = st.bus_sync[1];

    // ------------------------------------------------------------
    // Record new deviations while running
    // ------------------------------------------------------------
    next_st.dev_code = (running && !starting) ?
      (c & ~st.prev_cond) : monitor_panel_pkg::COND_NONE;
    next_st.dev_event = |next_st.dev_code;

    // ------------------------------------------------------------
    // Rear button restore, restart request one cycle later
    // ------------------------------------------------------------
    next_st.restore = hold_fired;
    next_st.restart = st.restore;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= monitor_panel_pkg::MON_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign start_stop_lamp = st.lamp;
  assign bus_activity_led = st.bus_led;
  assign present_led = st.present;
  assign latched_led = st.latched;
  assign isolated_error_out = st.iso_out;
  assign deviation_event = st.dev_event;
  assign deviation_code = st.dev_code;
  assign restore_defaults = st.restore;
  assign restart_request = st.restart;

endmodule // monitor_panel
`default_nettype wire

// *** bench/monitor_panel_chk.sv ***
// Concurrent checks on the ports of the monitor front panel
`default_nettype none
module monitor_panel_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bus_traffic,
  input wire monitor_panel_pkg::measures_t measures,
  input wire logic measures_valid,
  input wire monitor_panel_pkg::limits_t limits,
  input wire logic [monitor_panel_pkg::NUM_COND-1:0] output_assign,
  input wire logic start_stop_lamp,
  input wire logic bus_activity_led,
  input wire logic [monitor_panel_pkg::NUM_COND-1:0] present_led,
  input wire logic [monitor_panel_pkg::NUM_COND-1:0] latched_led,
  input wire logic isolated_error_out,
  input wire logic deviation_event,
  input wire logic [monitor_panel_pkg::NUM_COND-1:0] deviation_code,
  input wire logic restore_defaults,
  input wire logic restart_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_low_run;
    start_stop_lamp && measures_valid &&
      (measures.quality < limits.quality_min) ##1 start_stop_lamp;
  endsequence
  sequence s_restore;
    restore_defaults ##1 (restart_request && !restore_defaults);
  endsequence
  a_start_clears: assert property (
    $rose(start_stop_lamp) |-> (latched_led | present_led) == 8'h00)
    else $error("indicators not cleared at start");
  a_idle_dark: assert property (
    !start_stop_lamp |-> present_led == 8'h00)
    else $error("present indicator lit while idle");
  a_latch_holds: assert property (
    !$rose(start_stop_lamp) |->
      (latched_led & $past(latched_led)) == $past(latched_led))
    else $error("latched indicator dropped");
  a_present_latched: assert property (
    (present_led & ~latched_led) == 8'h00)
    else $error("present set without latched");
  a_quality_flag: assert property (
    s_low_run |-> present_led[monitor_panel_pkg::IDX_QUALITY])
    else $error("quality error not shown");
  a_iso_follows: assert property (
    isolated_error_out == |(latched_led & $past(output_assign)))
    else $error("isolated output mismatch");
  a_activity_delay: assert property (
    bus_activity_led == $past(bus_traffic, 3))
    else $error("activity led not traffic delayed");
  a_restore_pair: assert property (
    restore_defaults |-> s_restore)
    else $error("restart not one cycle after restore");
  a_deviation_code: assert property (
    deviation_event |-> deviation_code != 8'h00)
    else $error("deviation pulse without code");
  a_deviation_edges: assert property (
    deviation_code == (present_led & ~$past(present_led)))
    else $error("deviation code differs from new conditions");
endmodule // monitor_panel_chk
bind monitor_panel monitor_panel_chk monitor_panel_chk_inst (.clk, .rst_n,
  .bus_traffic, .measures, .measures_valid, .limits, .output_assign,
  .start_stop_lamp, .bus_activity_led, .present_led, .latched_led,
  .isolated_error_out, .deviation_event, .deviation_code,
  .restore_defaults, .restart_request);
`default_nettype wire

// *** bench/panel_operator.sv ***
// Model of the operator holding the rear restore button
`default_nettype none
module panel_operator (
  input wire logic clk,
  input wire logic press_go,
  input wire logic [7:0] press_len,
  output logic restore_button
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h00;
  // Button held without a break for the commanded count
  always @(posedge clk) begin
    if (left != 8'h00) begin
      left <= left - 8'h01;
    end else if (press_go) begin
      left <= press_len;
    end
  end
  assign restore_button = (left != 8'h00);
endmodule // panel_operator
`default_nettype wire

// *** bench/test_monitor_panel.sv ***
// Self-checking bench of the monitor front-panel logic
`default_nettype none
module test_monitor_panel;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ss = 1'b0;
  logic traffic = 1'b0;
  logic meas_ok = 1'b0;
  logic press_go = 1'b0;
  logic [7:0] press_len = 8'h00;
  logic [7:0] sel = 8'h00;
  monitor_panel_pkg::logical_events_t events = '0;
  monitor_panel_pkg::measures_t meas = 32'h80801010;
  monitor_panel_pkg::limits_t lim = 32'h40404040;
  logic restore, lamp, act, iso, dev, rd, rr;
  logic [7:0] pres, lat, dcode;
  int err_total = 0;
  int checked = 0;
  int restores = 0;
  int restarts = 0;
  int devs = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (rd === 1'b1) restores++;
  always @(posedge clk) if (rr === 1'b1) restarts++;
  always @(posedge clk) if (dev === 1'b1) devs++;
  monitor_panel #(.HOLD_CYCLES(20), .DEBOUNCE_CYCLES(4)) monitor_panel_inst (
    .clk(clk), .rst_n(rst_n), .start_stop_button(ss),
    .restore_button(restore), .bus_traffic(traffic), .logical_events(events),
    .measures(meas), .measures_valid(meas_ok), .limits(lim),
    .output_assign(sel), .start_stop_lamp(lamp), .bus_activity_led(act),
    .present_led(pres), .latched_led(lat), .isolated_error_out(iso),
    .deviation_event(dev), .deviation_code(dcode), .restore_defaults(rd),
    .restart_request(rr));
  panel_operator panel_operator_inst (.clk(clk), .press_go(press_go),
    .press_len(press_len), .restore_button(restore));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic press_ss();
    ss = 1'b1;
    tick(12);
    ss = 1'b0;
    tick(12);
  endtask
  task automatic t_start();
    check(lamp, 8'h00);
    check(pres | lat, 8'h00);
    press_ss();
    check(lamp, 8'h01);
  endtask
  task automatic t_logical();
    int d0;
    d0 = devs;
    for (int i = 0; i < 4; i++) begin
      events = 4'(4'h8 >> i);
      tick(6);
      check(pres, 8'(1 << i));
    end
    events = '0;
    tick(6);
    check(pres, 8'h00);
    check(lat, 8'h0F);
    check(8'(devs - d0), 8'h04);
  endtask
  task automatic t_physical();
    int d0;
    monitor_panel_pkg::measures_t m;
    d0 = devs;
    meas_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      m = 32'h80801010;
      m[(3 - i) * 8 +: 8] = 8'h40;
      meas = m;
      tick(3);
      check(pres, 8'h00);
      m[(3 - i) * 8 +: 8] = (i < 2) ? 8'h3F : 8'h41;
      meas = m;
      tick(3);
      check(pres, 8'(1 << (4 + i)));
    end
    meas = 32'h80801010;
    tick(3);
    check(lat, 8'hFF);
    check(8'(devs - d0), 8'h04);
  endtask
  task automatic t_isolate();
    for (int k = 0; k < 8; k++) begin
      sel = 8'(1 << k);
      tick(3);
      check(iso, 8'h01);
    end
    sel = 8'h00;
    tick(3);
    check(iso, 8'h00);
  endtask
  task automatic t_restart();
    int d0;
    events = 4'h8;
    tick(6);
    d0 = devs;
    press_ss();
    check(lamp, 8'h00);
    check(pres, 8'h00);
    check(lat, 8'hFF);
    press_ss();
    check(lamp, 8'h01);
    check(pres, 8'h01);
    check(lat, 8'h01);
    check(8'(devs - d0), 8'h01);
    events = '0;
  endtask
  task automatic t_activity();
    traffic = 1'b1;
    tick(5);
    check(act, 8'h01);
    traffic = 1'b0;
    tick(5);
    check(act, 8'h00);
  endtask
  task automatic t_restore(input logic [7:0] len, input int exp);
    press_len = len;
    press_go = 1'b1;
    tick(2);
    press_go = 1'b0;
    tick(50);
    check(8'(restores), 8'(exp));
    check(8'(restarts), 8'(exp));
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    tick(20);
    rst_n = 1'b1;
    tick(2);
    t_start();
    t_logical();
    t_physical();
    t_isolate();
    t_restart();
    t_activity();
    t_restore(8'h0A, 0);
    t_restore(8'h1E, 1);
    test_done();
  end
  // Cuts a hang short after about 4000 cycles
  initial begin
    #100000;
    err_total++;
    test_done();
  end
endmodule // test_monitor_panel
`default_nettype wire
